// *** fss_sequencer.sv ***
// supervisory sequencer core: start-up, protections, burst, x-cap discharge
// assumes comparator flags and osc pulses are synchronous to clk
`timescale 1ns/10ps
module fss_sequencer import fss_pkg::*; #(
    parameter int unsigned OVP_CYCLES   = OVP_CYC,
    parameter int unsigned LATCH_CYCLES = LATCH_CYC
) (
    // clock and reset
    input  wire logic     clk,
    input  wire logic     rst_b,
    input  wire logic     clk_en,
    // comparators
    input  wire fss_cmp_t cmp,
    // controls
    output fss_out_t      ctl_q
);
    // qualification counters are QUAL_W bits wide
    if (OVP_CYCLES < 1 || OVP_CYCLES >= (1 << QUAL_W)) begin : g_bad_ovp
        $error("bad OVP_CYCLES");
    end
    if (LATCH_CYCLES < 1 || LATCH_CYCLES >= (1 << QUAL_W)) begin : g_bad_latch
        $error("bad LATCH_CYCLES");
    end

    typedef enum logic [2:0] {
        ST_CHARGE, ST_CHECK, ST_DRAIN, ST_RUN, ST_XWAIT, ST_XDIS, ST_XDET, ST_LATCH
    } fss_state_t;

    logic       rst_s1_q, rst_s2_q;
    fss_cmp_t   c_q, c_prev_q;
    fss_state_t st_q;
    logic       first_q;
    logic [TC_W-1:0]   olp_q, bo_q, xc_q;
    logic [QUAL_W-1:0] ovp_q, tl_q;
    logic       olp_f_q, bo_f_q, tsd_q, burst_q, gate_q, ovp_f_q, tl_f_q;
    logic       tick, restart_lvl, fault, src_on;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // two stages so tick edge uses a registered copy only
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            c_q      <= '0;
            c_prev_q <= '0;
        end else if (clk_en) begin
            c_q      <= cmp;
            c_prev_q <= c_q;
        end
    end

    assign tick  = c_q.timer_top && !c_prev_q.timer_top;
    assign fault = olp_f_q || bo_f_q || tsd_q || c_q.cs_at_short;
    assign restart_lvl = fault || st_q == ST_DRAIN ? c_q.vcc_above_restart : c_q.vcc_above_supply_undervoltage_lockout;

    // overload and brown-out timers
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            olp_q   <= '0;
            bo_q    <= '0;
            olp_f_q <= 1'b0;
            bo_f_q  <= 1'b0;
        end else if (clk_en) begin
            if (!c_q.fb_above_overload) olp_q <= '0;
            else if (tick && olp_q != TC_W'(PROT_COUNT)) olp_q <= olp_q + 1'b1;
            if (!c_q.line_above_off) begin
                if (tick && bo_q != TC_W'(PROT_COUNT)) bo_q <= bo_q + 1'b1;
            end else bo_q <= '0;
            // flags drop only when the sequencer restarts from a recharge
            if (olp_q == TC_W'(PROT_COUNT)) olp_f_q <= 1'b1;
            else if (st_q == ST_CHARGE) olp_f_q <= 1'b0;
            if (bo_q == TC_W'(PROT_COUNT)) bo_f_q <= 1'b1;
            else if (st_q == ST_CHARGE) bo_f_q <= 1'b0;
        end
    end

    // thermal hysteresis and burst hysteresis
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            tsd_q   <= 1'b0;
            burst_q <= 1'b0;
        end else if (clk_en) begin
            if (c_q.hot_enter) tsd_q <= 1'b1;
            else if (c_q.hot_exit) tsd_q <= 1'b0;
            if (c_q.fb_below_burst_enter) burst_q <= 1'b1;
            else if (c_q.fb_above_burst_exit) burst_q <= 1'b0;
        end
    end

    // qualified latch-off sources
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ovp_q   <= '0;
            tl_q    <= '0;
            ovp_f_q <= 1'b0;
            tl_f_q  <= 1'b0;
        end else if (clk_en) begin
            ovp_q <= c_q.vcc_above_ovp ? ovp_q + 1'b1 : '0;
            if (ovp_q == QUAL_W'(OVP_CYCLES - 1) && c_q.vcc_above_ovp) ovp_f_q <= 1'b1;
            else ovp_f_q <= 1'b0;
            // timing pin is legitimately low in early soft start only while not run
            tl_q <= c_q.timer_low && st_q == ST_RUN ? tl_q + 1'b1 : '0;
            tl_f_q <= tl_q == QUAL_W'(LATCH_CYCLES - 1) && c_q.timer_low
                      && st_q == ST_RUN;
        end
    end

    // main sequence
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            st_q    <= ST_CHARGE;
            xc_q    <= '0;
            first_q <= 1'b1;
        end else if (clk_en) begin
            if (tick) xc_q <= xc_q + 1'b1;
            case (st_q)
                ST_CHARGE: if (c_q.vcc_above_start) st_q <= ST_CHECK;
                ST_CHECK: begin
                    if (c_q.line_above_on) st_q <= ST_RUN;
                    else if (!c_q.vcc_above_check) st_q <= ST_DRAIN;
                end
                ST_DRAIN: if (!c_q.vcc_above_restart) st_q <= ST_CHARGE;
                ST_RUN: begin
                    if (!restart_lvl) st_q <= ST_CHARGE;
                    else if (!c_q.line_above_off && bo_f_q) begin
                        st_q    <= ST_XWAIT;
                        xc_q    <= '0;
                        first_q <= 1'b1;
                    end
                end
                ST_XWAIT: begin
                    if (c_q.line_above_on) st_q <= ST_DRAIN;
                    else if (xc_q == TC_W'(XD_DELAY)) begin
                        st_q <= ST_XDIS;
                        xc_q <= '0;
                    end
                end
                ST_XDIS: begin
                    if (c_q.xcap_at_supply) st_q <= ST_CHARGE;
                    else if (xc_q == (first_q ? TC_W'(XD_FIRST) : TC_W'(XD_REPEAT))) begin
                        st_q    <= ST_XDET;
                        xc_q    <= '0;
                        first_q <= 1'b0;
                    end
                end
                ST_XDET: begin
                    if (c_q.line_above_on) st_q <= ST_DRAIN;
                    else if (xc_q == TC_W'(XD_DETECT)) begin
                        st_q <= ST_XDIS;
                        xc_q <= '0;
                    end
                end
                ST_LATCH: st_q <= ST_LATCH;
                default: st_q <= ST_CHARGE;
            endcase
            if (ovp_f_q || tl_f_q) st_q <= ST_LATCH;
        end
    end

    // latch leaves only when supply falls under 2.5V, handled as its own reset
    assign src_on = st_q == ST_CHARGE || st_q == ST_XDIS;

    // cycle-by-cycle gate: set on osc, end at peak or short
    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            gate_q <= 1'b0;
        end else if (clk_en) begin
            if (st_q != ST_RUN || fault || burst_q || olp_f_q) gate_q <= 1'b0;
            else if (c_q.blank_done && (c_q.cs_at_peak || c_q.cs_at_short))
                gate_q <= 1'b0;
            else if (c_q.osc_set) gate_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            ctl_q <= '0;
        end else if (clk_en) begin
            ctl_q.gate_drive_output <= gate_q && st_q == ST_RUN && !fault;
            ctl_q.hv_source_on      <= src_on;
            ctl_q.softstart_active  <= st_q == ST_RUN && c_q.timer_in_softstart;
            ctl_q.foldback_active   <= c_q.fb_in_foldback;
            ctl_q.freq_min_select   <= c_q.fb_below_foldback;
            ctl_q.burst_active      <= burst_q;
            ctl_q.fault_any         <= fault;
            ctl_q.latched           <= st_q == ST_LATCH;
        end
    end
endmodule

// *** fss_pkg.sv ***
// constants and carrier types for the flyback supervisory sequencer
// assumes analog comparators deliver flags synchronous to clk
package fss_pkg;
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned OVP_QUAL_NS  = 25_000;
    localparam int unsigned LATCH_QUAL_NS = 12_000;
    localparam int unsigned NS_PER_S     = 1_000_000_000;
    localparam int unsigned OVP_CYC   = (OVP_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned LATCH_CYC = (LATCH_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PROT_COUNT   = 17;
    localparam int unsigned XD_DELAY     = 32;
    localparam int unsigned XD_FIRST     = 16;
    localparam int unsigned XD_DETECT    = 16;
    localparam int unsigned XD_REPEAT    = 48;
    localparam int unsigned QUAL_W       = 10;
    localparam int unsigned TC_W         = 6;

    // comparator flags, each high when the named condition holds
    typedef struct packed {
        logic vcc_above_start;   // 14.5V
        logic vcc_above_check;   // 11.5V
        logic vcc_above_supply_undervoltage_lockout;    // 8.0V
        logic vcc_above_restart; // 5.3V
        logic vcc_above_ovp;     // 25V
        logic vcc_above_reset;   // 2.5V
        logic line_above_on;
        logic line_above_off;
        logic fb_below_burst_enter;
        logic fb_above_burst_exit;
        logic fb_above_overload;
        logic fb_in_foldback;
        logic fb_below_foldback;
        logic cs_at_peak;
        logic cs_at_short;
        logic hot_enter;         // above 150C
        logic hot_exit;          // below 125C
        logic timer_low;         // timing pin below 1.0V
        logic timer_in_softstart;
        logic timer_top;         // ramp reached 3.2V
        logic xcap_at_supply;
        logic osc_set;           // new switching cycle
        logic blank_done;
    } fss_cmp_t;

    typedef struct packed {
        logic gate_drive_output;
        logic hv_source_on;
        logic softstart_active;
        logic foldback_active;
        logic freq_min_select;
        logic burst_active;
        logic fault_any;
        logic latched;
    } fss_out_t;
endpackage

// *** fss_sequencer_asserts.sv ***
// checker for the supervisory sequencer, bound onto its ports
// assumes comparator flags are synchronous to clk
`timescale 1ns/10ps
module fss_sequencer_asserts import fss_pkg::*; #(
    parameter int unsigned OVP_CYCLES   = OVP_CYC,
    parameter int unsigned LATCH_CYCLES = LATCH_CYC
) (
    // clock and reset
    input wire logic     clk,
    input wire logic     rst_b,
    input wire logic     clk_en,
    // watched signals
    input wire fss_cmp_t cmp,
    input wire fss_out_t ctl_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_short; clk_en && cmp.cs_at_short; endsequence
    sequence s_hot; clk_en && cmp.hot_enter && !cmp.hot_exit; endsequence
    sequence s_ovp; clk_en && cmp.vcc_above_ovp; endsequence
    a_start_charges: assert property
        ($rose(rst_b) && clk_en |-> ##[1:6] ctl_q.hv_source_on)
        else $error("source not on after reset");
    a_gate_source_excl: assert property
        (ctl_q.gate_drive_output |-> !ctl_q.hv_source_on)
        else $error("gate and source on together");
    a_short_stops: assert property
        (s_short [*5] |-> !ctl_q.gate_drive_output)
        else $error("gate on during short");
    a_hot_stops: assert property
        (s_hot [*5] |-> !ctl_q.gate_drive_output)
        else $error("gate on while hot");
    a_ovp_latches: assert property
        (s_ovp [*8] |-> ##[0:4] ctl_q.latched)
        else $error("supply over-voltage not latched");
    a_latch_holds: assert property
        (ctl_q.latched |=> ctl_q.latched)
        else $error("latch released without reset");
    a_latch_no_gate: assert property
        (ctl_q.latched |-> !ctl_q.gate_drive_output)
        else $error("gate on while latched");
    a_burst_no_gate: assert property
        (ctl_q.burst_active [*3] |-> !ctl_q.gate_drive_output)
        else $error("gate on in burst pause");
endmodule

bind fss_sequencer fss_sequencer_asserts #(.OVP_CYCLES(OVP_CYCLES), .LATCH_CYCLES(LATCH_CYCLES))
    fss_sequencer_asserts_i (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cmp(cmp), .ctl_q(ctl_q));

// *** fss_power_stage.sv ***
// power stage and timing capacitor model beside the sequencer
// assumes gate and bench flags are synchronous to clk
`timescale 1ns/10ps
module fss_power_stage import fss_pkg::*; (
    // clock and stimulus
    input wire logic       clk,
    input wire logic       gate,
    input wire logic [3:0] ramp,
    input wire fss_cmp_t   drv,
    // flags to the sequencer
    output fss_cmp_t       cmp
);
    int i_q = 0;
    int t_q = 0;
    always_ff @(posedge clk) begin
        i_q <= gate ? i_q + 1 : 0;
    end
    // fixed 12-clock ramp so the bench can count ticks
    always_ff @(posedge clk) begin
        t_q <= (t_q == 11) ? 0 : t_q + 1;
    end
    always_comb begin
        cmp = drv;
        cmp.cs_at_peak = gate && i_q >= int'(ramp);
        cmp.blank_done = i_q > 1;
        cmp.timer_top = t_q < 6;
        cmp.osc_set = t_q % 4 == 0;
    end
endmodule

// *** flyback_supervisory_sequencer_test.sv ***
// self-checking bench for the supervisory sequencer
// assumes the power stage model supplies current, osc and timing flags
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module flyback_supervisory_sequencer_test;
    import fss_pkg::*;
    // supply, line, feedback and temperature at normal levels
    localparam fss_cmp_t NORMAL = 23'h3aa040;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic [3:0]  ramp = 4'h4;
    fss_cmp_t    drv = '0;
    fss_cmp_t    cmp;
    fss_out_t    ctl_q;
    logic [7:0]  o;
    int unsigned seed = 7809;
    int          mismatches = 0;
    int          total_checks = 0;
    int          waited = 0;
    // clocks per timing tick in the power stage model
    localparam int TICK = 12;
    assign o = ctl_q;
    always #12.5 clk = ~clk;
    fss_sequencer #(.OVP_CYCLES(4), .LATCH_CYCLES(4)) fss_sequencer_i (.clk(clk),
        .rst_b(rst_b), .clk_en(clk_en), .cmp(cmp), .ctl_q(ctl_q));
    fss_power_stage fss_power_stage_i (.clk(clk), .gate(ctl_q.gate_drive_output),
        .ramp(ramp), .drv(drv), .cmp(cmp));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // always spends an edge so two drives never share a time step
    task automatic wt(input int k, input logic v, input string nm);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (o[k] !== v && n < 3000);
        waited = n;
        `CHK(nm, v, o[k]);
        if (n >= 3000) stop_test();
    endtask
    task automatic up();
        rst_b <= 1'b0;
        drv <= NORMAL;
        ramp <= 4'(2 + xs() % 8);
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        wt(6, 1'b1, "hv_source_on");
        drv.vcc_above_start <= 1'b1;
        wt(6, 1'b0, "hv_source_on");
        `CHK("gate", 1'b0, o[7]);
        drv.line_above_on <= 1'b1;
        wt(7, 1'b1, "gate");
        wt(7, 1'b0, "gate");
    endtask
    task automatic flag(input bit bo, input logic v);
        if (bo) drv.line_above_off <= !v;
        else drv.fb_above_overload <= v;
    endtask
    // count model: ten ticks, a removal, then 16 and 18 ticks
    task automatic trip(input bit bo);
        int cnt;
        repeat (xs() % 12) @(posedge clk);
        flag(bo, 1'b1);
        repeat (120) @(posedge clk);
        flag(bo, 1'b0);
        @(posedge clk);
        flag(bo, 1'b1);
        cnt = 16;
        repeat (192) @(posedge clk);
        `CHK("fault", 1'(cnt >= PROT_COUNT), o[1]);
        cnt += 2;
        repeat (24) @(posedge clk);
        `CHK("fault", 1'(cnt >= PROT_COUNT), o[1]);
        `CHK("gate", 1'b0, o[7]);
    endtask
    initial begin
        up();
        drv.fb_above_burst_exit <= 1'b0;
        @(posedge clk);
        drv.fb_below_burst_enter <= 1'b1;
        wt(2, 1'b1, "burst");
        drv.fb_below_burst_enter <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("burst", 1'b1, o[2]);
        drv.fb_above_burst_exit <= 1'b1;
        wt(2, 1'b0, "burst");
        drv.cs_at_short <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("gate", 1'b0, o[7]);
        drv.cs_at_short <= 1'b0;
        wt(7, 1'b1, "gate");
        drv.hot_enter <= 1'b1;
        @(posedge clk);
        drv.hot_exit <= 1'b0;
        wt(1, 1'b1, "fault");
        drv.hot_enter <= 1'b0;
        @(posedge clk);
        drv.hot_exit <= 1'b1;
        wt(7, 1'b1, "gate");
        drv.fb_in_foldback <= 1'b1;
        wt(4, 1'b1, "foldback");
        drv.fb_below_foldback <= 1'b1;
        wt(3, 1'b1, "freq_min");
        drv.timer_in_softstart <= 1'b1;
        wt(5, 1'b1, "softstart");
        drv.vcc_above_supply_undervoltage_lockout <= 1'b0;
        wt(6, 1'b1, "hv_source_on");
        `CHK("gate", 1'b0, o[7]);
        up();
        trip(1'b0);
        up();
        trip(1'b1);
        up();
        drv.vcc_above_ovp <= 1'b1;
        wt(0, 1'b1, "latched");
        repeat (8) @(posedge clk);
        drv.vcc_above_ovp <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("latched", 1'b1, o[0]);
        // line lost: brown-out, then x-cap discharge cycles counted in ticks
        up();
        drv.line_above_on <= 1'b0;
        drv.line_above_off <= 1'b0;
        wt(1, 1'b1, "fault");
        wt(6, 1'b1, "hv_source_on");
        `CHK("xwait_len", 1'b1, 1'(waited > (XD_DELAY - 1) * TICK && waited <= XD_DELAY * TICK + 4));
        `CHK("gate", 1'b0, o[7]);
        wt(6, 1'b0, "hv_source_on");
        `CHK("xdis_len", 1'b1, 1'(waited > (XD_FIRST - 1) * TICK && waited <= XD_FIRST * TICK + 4));
        wt(6, 1'b1, "hv_source_on");
        `CHK("xdet_len", 1'b1, 1'(waited > (XD_DETECT - 1) * TICK && waited <= XD_DETECT * TICK + 4));
        wt(6, 1'b0, "hv_source_on");
        `CHK("xrep_len", 1'b1, 1'(waited > (XD_REPEAT - 1) * TICK && waited <= XD_REPEAT * TICK + 4));
        wt(6, 1'b1, "hv_source_on");
        drv.xcap_at_supply <= 1'b1;
        wt(6, 1'b0, "hv_source_on");
        drv.vcc_above_check <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("hv_source_on", 1'b0, o[6]);
        `CHK("gate", 1'b0, o[7]);
        drv.vcc_above_restart <= 1'b0;
        wt(6, 1'b1, "hv_source_on");
        up();
        drv.timer_low <= 1'b1;
        wt(0, 1'b1, "latched");
        stop_test();
    end
endmodule
